// file: core/gpio_flag_bank.sv
// Level-fed write-one-to-clear GPIO interrupt flags with wake clear pulses
`timescale 1ns/10ps
`default_nettype none
module gpio_flag_bank #(
   parameter int N = 8,
   parameter int INIT_CYC = interrupt_status_pkg::GPIO_INIT_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [N-1:0] src,
   input wire logic [N-1:0] clr,
   output logic [N-1:0] flags,
   output logic [N-1:0] wake_clr
);

   localparam int CNT_W = $clog2(INIT_CYC + 1);

   typedef struct packed {
      logic [CNT_W-1:0] init_cnt;
      logic [N-1:0] flags;
      logic [N-1:0] wake_clr;
   } bank_state_t;

   bank_state_t st_r;
   bank_state_t st_nxt;

   if (N < 1 || N > interrupt_status_pkg::GPIO_MAX || INIT_CYC < 1) begin : g_bad_cfg
      $error("gpio_flag_bank configuration out of range");
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.wake_clr = '0;
      if (st_r.init_cnt != '0) begin
         // Follow the synchronised pins until they carry real pin state
         st_nxt.init_cnt = st_r.init_cnt - CNT_W'(1);
         st_nxt.flags = src; // see RULE8
      end else begin
         // Level source wins over a clear in the same cycle
         st_nxt.flags = (st_r.flags & ~clr) | src; // see RULE6 see RULE7 see RULE10
         st_nxt.wake_clr = clr; // see RULE9
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '{init_cnt: CNT_W'(INIT_CYC), flags: '0, wake_clr: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flags = st_r.flags;
   assign wake_clr = st_r.wake_clr;

endmodule : gpio_flag_bank
`default_nettype wire

// file: core/interrupt_status_low_half.sv
// Interrupt status low half with data port engine behind an Avalon-MM slave
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module interrupt_status_low_half #(
   parameter int GPIO_N = interrupt_status_pkg::GPIO_MAX,
   parameter int ERR_W = 32,
   parameter int FRM_W = 8,
   parameter int DP_LATENCY_CYC = interrupt_status_pkg::DP_LATENCY_CYC_DEF
) (
   input wire logic clock,
   input wire logic rst,
   input wire interrupt_status_pkg::avmm_req_t bus_req,
   output interrupt_status_pkg::avmm_rsp_t bus_rsp,
   input wire logic [ERR_W-1:0] mac_error_status_register,
   input wire logic [FRM_W-1:0] usb_tx_frames,
   input wire logic [GPIO_N-1:0] gpio_pin,
   output logic [GPIO_N-1:0] gpio_wake_clear
);

   localparam int CNT_W = $clog2(DP_LATENCY_CYC + 1);
   localparam int DW = interrupt_status_pkg::DATA_W;

   // ============================================================
   // Configuration checks
   if (GPIO_N < 1 || GPIO_N > interrupt_status_pkg::GPIO_MAX) begin : g_bad_gpio
      $error("GPIO count must be 1 to 8");
   end
   if (ERR_W < 1 || ERR_W > DW || FRM_W < 1) begin : g_bad_width
      $error("error or frame count width out of range");
   end
   // The completion check uses a plain delay of this length, so keep it short
   if (DP_LATENCY_CYC < 1 || DP_LATENCY_CYC > 256) begin : g_bad_lat
      $error("data port latency out of range");
   end

   // ============================================================
   // State
   typedef struct packed {
      logic ack;
      logic [DW-1:0] rdata;
      logic dp_flag;
      logic mac_flag;
      logic dp_busy;
      logic [CNT_W-1:0] dp_cnt;
      logic dp_done;
   } core_state_t;

   core_state_t st_r;
   core_state_t st_nxt;

   logic req_any;
   logic wr_fire;
   logic [DW-1:0] be_bits;
   logic [DW-1:0] sts_clear;
   logic [DW-1:0] sts_view;
   logic [DW-1:0] ctrl_view;
   logic [DW-1:0] err_view;
   logic [DW-1:0] rd_mux;
   logic dp_start;
   logic mac_any;
   logic utx_wait;
   logic [GPIO_N-1:0] gpio_sync;
   logic [GPIO_N-1:0] gpio_flags;
   logic [GPIO_N-1:0] gpio_clear;

   function automatic logic [DW-1:0] be_expand(input logic [interrupt_status_pkg::BE_W-1:0] be);
      logic [DW-1:0] m;
      m = '0;
      for (int i = 0; i < interrupt_status_pkg::BE_W; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction : be_expand

   // ============================================================
   // GPIO path
   sync_2ff #(
      .W(GPIO_N)
   ) u_gpio_sync (
      .clock(clock),
      .rst(rst),
      .d(gpio_pin),
      .q(gpio_sync)
   );

   gpio_flag_bank #(
      .N(GPIO_N),
      .INIT_CYC(interrupt_status_pkg::GPIO_INIT_CYC)
   ) u_gpio_bank (
      .clock(clock),
      .rst(rst),
      .src(gpio_sync),
      .clr(gpio_clear),
      .flags(gpio_flags),
      .wake_clr(gpio_wake_clear)
   );

   // ============================================================
   // Bus decode
   assign req_any = bus_req.read | bus_req.write;
   assign wr_fire = bus_req.write & st_r.ack;
   assign be_bits = be_expand(bus_req.byteenable);

   // Only implemented write-one-to-clear bits can clear; reserved bits drop out
   always_comb begin
      sts_clear = '0;
      if (wr_fire && bus_req.address == interrupt_status_pkg::OFS_INTERRUPT_STATUS) begin
         sts_clear = bus_req.writedata & be_bits & interrupt_status_pkg::STS_WC_MASK; // see RULE10
      end
   end

   assign gpio_clear = sts_clear[interrupt_status_pkg::GPIO_LSB +: GPIO_N];
   assign dp_start = wr_fire && bus_req.address == interrupt_status_pkg::OFS_DP_CTRL &&
                     bus_req.byteenable[0] && bus_req.writedata[interrupt_status_pkg::BIT_DP_START] &&
                     !st_r.dp_busy;
   assign mac_any = |mac_error_status_register;
   assign utx_wait = usb_tx_frames != '0; // see RULE5

   // ============================================================
   // Read views
   always_comb begin
      sts_view = interrupt_status_pkg::ZERO_WORD;
      sts_view[interrupt_status_pkg::BIT_DP_DONE] = st_r.dp_flag;
      sts_view[interrupt_status_pkg::BIT_MAC_ERR] = st_r.mac_flag;
      sts_view[interrupt_status_pkg::BIT_UTX_WAIT] = utx_wait; // see RULE5
      sts_view[interrupt_status_pkg::GPIO_LSB +: GPIO_N] = gpio_flags; // see RULE6
      ctrl_view = interrupt_status_pkg::ZERO_WORD;
      ctrl_view[interrupt_status_pkg::BIT_DP_BUSY] = st_r.dp_busy;
      err_view = interrupt_status_pkg::ZERO_WORD;
      err_view[ERR_W-1:0] = mac_error_status_register;
   end

   always_comb begin
      case (bus_req.address)
         interrupt_status_pkg::OFS_INTERRUPT_STATUS: begin
            rd_mux = sts_view;
         end
         interrupt_status_pkg::OFS_DP_CTRL: begin
            rd_mux = ctrl_view;
         end
         interrupt_status_pkg::OFS_ERR_VIEW: begin
            rd_mux = err_view;
         end
         default: begin
            rd_mux = interrupt_status_pkg::ZERO_WORD;
         end
      endcase
   end

   // ============================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      // One wait cycle for every access, then answer
      st_nxt.ack = req_any & ~st_r.ack;
      if (req_any && !st_r.ack) begin
         st_nxt.rdata = bus_req.read ? rd_mux : interrupt_status_pkg::ZERO_WORD;
      end

      // Data port engine: busy for the latency, then a one-cycle done pulse
      st_nxt.dp_done = 1'b0;
      if (dp_start) begin
         st_nxt.dp_busy = 1'b1;
         st_nxt.dp_cnt = CNT_W'(DP_LATENCY_CYC - 1);
      end else if (st_r.dp_busy) begin
         if (st_r.dp_cnt == '0) begin
            st_nxt.dp_busy = 1'b0;
            st_nxt.dp_done = 1'b1; // see RULE2
         end else begin
            st_nxt.dp_cnt = st_r.dp_cnt - CNT_W'(1);
         end
      end

      // Set wins over a clear in the same cycle
      st_nxt.dp_flag = (st_r.dp_flag & ~sts_clear[interrupt_status_pkg::BIT_DP_DONE]) |
                       st_r.dp_done; // see RULE1
      st_nxt.mac_flag = (st_r.mac_flag & ~sts_clear[interrupt_status_pkg::BIT_MAC_ERR]) |
                        mac_any; // see RULE3 see RULE4
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '0; // see RULE1 see RULE3
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus_rsp.readdata = st_r.rdata;
   assign bus_rsp.waitrequest = req_any & ~st_r.ack;

   // ============================================================
   // Assertions
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence dp_launch_s;
      $rose(st_r.dp_busy);
   endsequence

   sequence dp_finish_s;
      st_r.dp_done ##1 st_r.dp_flag;
   endsequence

   sequence sts_read_s;
      bus_req.read && !st_r.ack && bus_req.address == interrupt_status_pkg::OFS_INTERRUPT_STATUS;
   endsequence

   sequence sts_write_s;
      wr_fire && bus_req.address == interrupt_status_pkg::OFS_INTERRUPT_STATUS;
   endsequence

   dp_flag_latch_a: assert property (st_r.dp_done |=> st_r.dp_flag && !st_r.dp_done) // see RULE1
      else $error("done pulse not latched or not single");

   dp_op_done_a: assert property (dp_launch_s |-> ##DP_LATENCY_CYC dp_finish_s) // see RULE2
      else $error("data port completion late or missing");

   mac_err_set_a: assert property (mac_any |=> st_r.mac_flag) // see RULE3
      else $error("MAC error summary did not set");

   mac_err_level_a: assert property (sts_write_s ##0 mac_any |=> st_r.mac_flag) // see RULE4
      else $error("MAC error summary cleared while error present");

   utx_wait_read_a: assert property (sts_read_s |=>
      st_r.rdata[interrupt_status_pkg::BIT_UTX_WAIT] == ($past(usb_tx_frames) != '0)) // see RULE5
      else $error("frame waiting flag wrong on read");

   gpio_level_set_a: assert property (##1 (gpio_flags & $past(gpio_sync)) == $past(gpio_sync)) // see RULE7
      else $error("GPIO flag missing while source level high");

   gpio_wake_clr_a: assert property (gpio_clear != '0 && $past(!rst) |=>
      gpio_wake_clear == $past(gpio_clear) || $past(gpio_wake_clear) == '0) // see RULE9
      else $error("wake clear does not follow GPIO flag clear");

   w1c_zero_keep_a: assert property (sts_write_s ##0 st_r.dp_flag &&
      !sts_clear[interrupt_status_pkg::BIT_DP_DONE] |=> st_r.dp_flag) // see RULE10
      else $error("writing zero cleared a flag");

   rsv_read_zero_a: assert property (sts_read_s |=>
      (st_r.rdata & interrupt_status_pkg::STS_RSV_MASK) == interrupt_status_pkg::ZERO_WORD) // see RULE10
      else $error("reserved status bits not zero");

   bus_answer_a: assert property (req_any |-> ##[0:1] !bus_rsp.waitrequest)
      else $error("slave did not answer within one wait cycle");

endmodule : interrupt_status_low_half
`default_nettype wire

// file: core/interrupt_status_pkg.sv
// Constants and types for the low half of the interrupt status register
// ============================================================
// Behaviour
// RULE1: Bit 16 latches a one-cycle completion pulse, is cleared by writing one and resets to zero.
// RULE2: The completion pulse fires when a data port operation that software started has finished.
// RULE3: Bit 15 sets whenever any bit of the MAC error status input is set and resets to zero.
// RULE4: Bit 15 is a level flag that stays set while any MAC error bit remains set.
// RULE5: Bit 12 reads high while the USB transmit FIFO holds at least one whole frame and resets to zero.
// RULE6: Bits 7 to 0 are one flag per GPIO, each fed by a level from its pin and cleared by writing one.
// RULE7: A GPIO flag sets again right after clearing while its pin level is still present.
// RULE8: After reset each GPIO flag takes the state of its pin, not a fixed constant.
// RULE9: Clearing a GPIO flag also clears the wake event recorded for that GPIO.
// RULE10: Writing one clears a flag, writing zero leaves it, and reserved bits read zero and ignore writes.
package interrupt_status_pkg;

   // ============================================================
   // Bus shape
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [BE_W-1:0] byteenable;
      logic [DATA_W-1:0] writedata;
   } avmm_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic waitrequest;
   } avmm_rsp_t;

   // ============================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_DP_CTRL = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_ERR_VIEW = 4'h8;

   // ============================================================
   // Interrupt status fields
   localparam int BIT_DP_DONE = 16;
   localparam int BIT_MAC_ERR = 15;
   localparam int BIT_UTX_WAIT = 12;
   localparam int GPIO_LSB = 0;
   localparam int GPIO_MAX = 8;
   localparam logic [DATA_W-1:0] STS_WC_MASK = 32'h0001_80ff;
   localparam logic [DATA_W-1:0] STS_RSV_MASK = 32'h0000_6f00;

   // ============================================================
   // Data port control fields
   localparam int BIT_DP_START = 0;
   localparam int BIT_DP_BUSY = 1;

   // ============================================================
   // Reset values and timing
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DP_LATENCY_NS = 160;
   localparam int DP_LATENCY_CYC_DEF = (DP_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   localparam int GPIO_INIT_CYC = SYNC_STAGES + 1;

endpackage : interrupt_status_pkg

// file: core/sync_2ff.sv
// Two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   if (W < 1) begin : g_bad_w
      $error("sync_2ff width must be at least one");
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;

endmodule : sync_2ff
`default_nettype wire

// file: verif/tb_interrupt_status_low_half.sv
// Self-checking bench for the interrupt status low half over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_status_low_half;
   logic clock;
   logic rst;
   interrupt_status_pkg::avmm_req_t bus_req;
   interrupt_status_pkg::avmm_rsp_t bus_rsp;
   logic [31:0] err_in;
   logic [7:0] frames;
   logic [7:0] pins;
   logic [7:0] wake;
   logic [31:0] rd;
   int error_cnt;
   int checked;

   interrupt_status_low_half #(
      .GPIO_N(8),
      .ERR_W(32),
      .FRM_W(8),
      .DP_LATENCY_CYC(2)
   ) dut (
      .clock(clock),
      .rst(rst),
      .bus_req(bus_req),
      .bus_rsp(bus_rsp),
      .mac_error_status_register(err_in),
      .usb_tx_frames(frames),
      .gpio_pin(pins),
      .gpio_wake_clear(wake)
   );

   // ============================================================
   // Clock and watchdog
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial begin
      #200000;
      error_cnt++;
      $display("[ERR] %0t: watchdog expired", $time);
      stop_test();
   end

   // ============================================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Holds the request until waitrequest is sampled low, then releases it
   task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      bus_req.read <= ~wr;
      bus_req.write <= wr;
      bus_req.address <= addr;
      bus_req.byteenable <= 4'hf;
      bus_req.writedata <= wd;
      do begin
         @(posedge clock);
         n++;
      end while (bus_rsp.waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         $display("[ERR] %0t: no bus answer", $time);
      end
      rd = bus_rsp.readdata;
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
   endtask : access

   task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
      access(1'b0, addr, 32'h0000_0000);
      chk(rd, exp);
   endtask : rd_chk

   // Status write, then look at the wake clear pulse in the following cycle
   task automatic clr(input logic [31:0] wd, input logic [7:0] exp_wake);
      access(1'b1, interrupt_status_pkg::OFS_INTERRUPT_STATUS, wd);
      @(posedge clock);
      chk({24'h00_0000, wake}, {24'h00_0000, exp_wake});
   endtask : clr

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // ============================================================
   // Test sequence
   initial begin
      int n;
      error_cnt = 0;
      checked = 0;
      rst = 1'b1;
      bus_req = '0;
      err_in = 32'h0000_0000;
      frames = 8'h00;
      pins = 8'ha5;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_00a5);
      pins <= 8'h00;
      repeat (4) @(posedge clock);
      clr(32'h0000_00ff, 8'hff);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0000);
      pins <= 8'h3c;
      repeat (4) @(posedge clock);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_003c);
      clr(32'h0000_0000, 8'h00);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_003c);
      clr(32'h0000_0004, 8'h04);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_003c);
      pins <= 8'h00;
      repeat (4) @(posedge clock);
      clr(32'h0000_0014, 8'h14);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0028);
      clr(32'hffff_ffff, 8'hff);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0000);
      // Frame waiting flag is read-only and follows the frame count
      frames <= 8'h03;
      repeat (2) @(posedge clock);
      clr(32'h0000_1000, 8'h00);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_1000);
      frames <= 8'h00;
      repeat (2) @(posedge clock);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0000);
      // MAC error summary holds while any error bit stays set
      err_in <= 32'h8000_0100;
      repeat (2) @(posedge clock);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_8000);
      rd_chk(interrupt_status_pkg::OFS_ERR_VIEW, 32'h8000_0100);
      clr(32'h0000_8000, 8'h00);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_8000);
      err_in <= 32'h0000_0000;
      repeat (2) @(posedge clock);
      clr(32'h0000_8000, 8'h00);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0000);
      // Data port operation completes and latches the done flag
      access(1'b1, interrupt_status_pkg::OFS_DP_CTRL, 32'h0000_0001);
      n = 0;
      do begin
         access(1'b0, interrupt_status_pkg::OFS_DP_CTRL, 32'h0000_0000);
         n++;
      end while (rd[interrupt_status_pkg::BIT_DP_BUSY] !== 1'b0 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         $display("[ERR] %0t: data port stayed busy", $time);
      end
      repeat (4) @(posedge clock);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0001_0000);
      clr(32'h0000_0000, 8'h00);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0001_0000);
      clr(32'h0001_0000, 8'h00);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0000);
      // Unmapped place reads zero and ignores writes
      access(1'b1, 4'hc, 32'hffff_ffff);
      rd_chk(4'hc, 32'h0000_0000);
      rd_chk(interrupt_status_pkg::OFS_INTERRUPT_STATUS, 32'h0000_0000);
      stop_test();
   end
endmodule : tb_interrupt_status_low_half
`default_nettype wire
